// [spc_pkg.sv]
// Package for the sensor and auxiliary pin control block: register map, fields, reset values and carriers.
package spc_pkg;

   // Register indices; the byte address on the bus is four times the index.
   localparam logic [9:0] SPC_IDX_SENSOR = 10'h058;
   localparam logic [9:0] SPC_IDX_AUX = 10'h059;
   localparam logic [9:0] SPC_IDX_STATUS = 10'h060;
   localparam logic [9:0] SPC_IDX_COMMAND = 10'h061;
   localparam logic [9:0] SPC_IDX_TRIP_LINES = 10'h062;
   localparam logic [9:0] SPC_IDX_IRQ_STATUS = 10'h063;
   localparam logic [9:0] SPC_IDX_IRQ_MASK = 10'h064;

   // Field positions in paper_sensor_config.
   localparam int unsigned SPC_PS_POL = 3;
   localparam int unsigned SPC_PS_EDGE = 4;
   localparam int unsigned SPC_PS_STOP = 5;

   // Field positions in aux_pin_config for pin 1; pin 2 sits four bits higher.
   localparam int unsigned SPC_AUX_DIR = 0;
   localparam int unsigned SPC_AUX_POL = 1;
   localparam int unsigned SPC_AUX_EDGE = 2;
   localparam int unsigned SPC_AUX_OUT = 3;
   localparam int unsigned SPC_AUX_STRIDE = 4;

   // Field positions in the status register.
   localparam int unsigned SPC_ST_SCANNING = 3;
   localparam int unsigned SPC_ST_PENDING = 4;

   // Interrupt status bits.
   localparam int unsigned SPC_IRQ_SENSOR = 0;
   localparam int unsigned SPC_IRQ_AUX1 = 1;
   localparam int unsigned SPC_IRQ_AUX2 = 2;
   localparam int unsigned SPC_IRQ_STOPPED = 3;

   // Reset values.
   localparam logic [7:0] SPC_RESET_CFG = 8'h00;
   localparam logic [7:0] SPC_RESET_COMMAND = 8'h00;
   localparam logic [7:0] SPC_RESET_TRIP_LINES = 8'h00;
   localparam logic [3:0] SPC_RESET_IRQ = 4'h0;

   // APB request from the master.
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } spc_apb_req_t;

   // State of one input conditioner.
   typedef struct packed {
      logic [1:0] sync;
      logic true_q;
      logic latch;
   } spc_cond_t;

   // State of the main block.
   typedef struct packed {
      logic [7:0] sensor_cfg;
      logic [7:0] aux_cfg;
      logic [7:0] command;
      logic [7:0] trip_lines;
      logic [7:0] remaining;
      logic pending;
      logic [3:0] irq_stat;
      logic [3:0] irq_mask;
      logic [31:0] prdata;
      logic pslverr;
   } spc_state_t;

endpackage

// [spc_input_cond.sv]
// Input conditioner: synchroniser, polarity, level or edge capture for one pin.
`timescale 1ns/1ps
module spc_input_cond import spc_pkg::*; (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic pin_in,
   input wire logic polarity_in,
   input wire logic edge_mode_in,
   input wire logic enable_in,
   input wire logic read_clear_in,
   output logic true_out,
   output logic rise_out,
   output logic state_out
);

   spc_cond_t st;
   spc_cond_t next_st;

   // The pin is "true" after two sync stages; a disabled input reads as never true.
   assign true_out = enable_in & (polarity_in ? st.sync[1] : ~st.sync[1]);
   assign rise_out = true_out & ~st.true_q;
   // A latch left over from input use must not show in the cycle in which the pin turns into an output.
   assign state_out = edge_mode_in ? (st.latch & enable_in) : true_out;

   // The latch holds a sighting until a status read; a sighting in the clear cycle wins.
   always_comb begin
      next_st = st;
      next_st.sync = {st.sync[0], pin_in};
      next_st.true_q = true_out;
      if (enable_in && edge_mode_in) begin
         next_st.latch = (st.latch & ~read_clear_in) | true_out;
      end else begin
         next_st.latch = 1'b0;
      end
   end

   // Single state register.
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         // The previous truth starts high, so a pin that is already true after reset raises no false edge.
         st <= '{sync: 2'h0, true_q: 1'b1, latch: 1'b0};
      end else begin
         st <= next_st;
      end
   end

endmodule

// [spc_pin_ctrl.sv]
// Paper sensor and auxiliary pin control with APB registers and interrupt.
//
// Contract
// - Sensor edge mode: status latches true since read.
// - Stop option off: scan state untouched.
// - Stop option on: rising trip clears command.
// - Stop deferred by programmed post-trip line count.
// - Aux pin 1 direction: 0 input, 1 output.
// - Aux pin 1 polarity selects true level.
// - Aux pin 1 level mode reports current truth.
// - Aux pin 1 edge mode latches until read.
// - Aux pin 1 output bit drives level.
// - Aux pin 2 direction: 0 input, 1 output.
// - Aux pin 2 polarity selects true level.
// - Aux pin 2 level mode reports current truth.
// - Sensor polarity selects true level.
// - Sensor level mode reports current truth.
// - Aux pin 2 edge mode latches until read.
`timescale 1ns/1ps
module spc_pin_ctrl import spc_pkg::*; (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire spc_apb_req_t apb_in,
   output logic pready_out,
   output logic pslverr_out,
   output logic [31:0] prdata_out,
   input wire logic sensor2_in,
   input wire logic [1:0] aux_pin_in,
   output logic [1:0] aux_pin_out,
   output logic [1:0] aux_pin_oe_out,
   input wire logic line_done_in,
   output logic [7:0] command_out,
   output logic irq_out
);

   spc_state_t st;
   spc_state_t next_st;

   logic [2:0] pins;
   logic [2:0] pol;
   logic [2:0] edge_mode;
   logic [2:0] enable;
   logic [2:0] read_clear;
   logic [2:0] cond_true;
   logic [2:0] cond_rise;
   logic [2:0] cond_state;
   logic [9:0] word;
   logic setup;
   logic done;
   logic wr;
   logic hit;
   logic [31:0] rd_val;
   logic [7:0] status;
   logic cmd_wr;
   logic trip;
   logic stop_now;

   // Inputs in order sensor, aux 1, aux 2; an aux pin set as output is masked off.
   assign pins = {aux_pin_in[1], aux_pin_in[0], sensor2_in};
   assign pol = {st.aux_cfg[SPC_AUX_STRIDE + SPC_AUX_POL], st.aux_cfg[SPC_AUX_POL],
                 st.sensor_cfg[SPC_PS_POL]};
   assign edge_mode = {st.aux_cfg[SPC_AUX_STRIDE + SPC_AUX_EDGE], st.aux_cfg[SPC_AUX_EDGE],
                       st.sensor_cfg[SPC_PS_EDGE]};
   assign enable = {~st.aux_cfg[SPC_AUX_STRIDE + SPC_AUX_DIR], ~st.aux_cfg[SPC_AUX_DIR], 1'b1};

   // Only bits that the finished status read actually returned are cleared.
   assign read_clear = (done && !apb_in.pwrite && word == SPC_IDX_STATUS) ? st.prdata[2:0] : 3'h0;

   // One conditioner per input, each with its own two-stage synchroniser.
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_cond
         spc_input_cond u_cond (
            .clk_in(clk_in),
            .reset_in(reset_in),
            .pin_in(pins[gi]),
            .polarity_in(pol[gi]),
            .edge_mode_in(edge_mode[gi]),
            .enable_in(enable[gi]),
            .read_clear_in(read_clear[gi]),
            .true_out(cond_true[gi]),
            .rise_out(cond_rise[gi]),
            .state_out(cond_state[gi])
         );
      end
   endgenerate

   // Aux pins drive from configuration flops only while set as outputs.
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         aux_pin_oe_out[i] = st.aux_cfg[i * SPC_AUX_STRIDE + SPC_AUX_DIR];
         aux_pin_out[i] = st.aux_cfg[i * SPC_AUX_STRIDE + SPC_AUX_OUT];
      end
   end

   // Bus phases and the status view.
   assign word = apb_in.paddr[11:2];
   assign setup = apb_in.psel & ~apb_in.penable;
   assign done = apb_in.psel & apb_in.penable;
   assign wr = done & apb_in.pwrite & ~st.pslverr;
   assign cmd_wr = wr && word == SPC_IDX_COMMAND;
   assign status = {3'h0, st.pending, st.command[0], cond_state};

   // A trip counts only while scanning with the stop option on.
   assign trip = cond_rise[0] & st.sensor_cfg[SPC_PS_STOP] & st.command[0] & ~st.pending;
   assign stop_now = st.sensor_cfg[SPC_PS_STOP] &&
                     ((trip && st.trip_lines == 8'h00) ||
                      (st.pending && line_done_in && st.remaining == 8'h01));

   // Read multiplexer; unmapped words answer with an error and zero data.
   always_comb begin
      hit = 1'b1;
      rd_val = 32'h0000_0000;
      unique case (word)
         SPC_IDX_SENSOR: rd_val = {24'h00_0000, st.sensor_cfg};
         SPC_IDX_AUX: rd_val = {24'h00_0000, st.aux_cfg};
         SPC_IDX_STATUS: rd_val = {24'h00_0000, status};
         SPC_IDX_COMMAND: rd_val = {24'h00_0000, st.command};
         SPC_IDX_TRIP_LINES: rd_val = {24'h00_0000, st.trip_lines};
         SPC_IDX_IRQ_STATUS: rd_val = {28'h000_0000, st.irq_stat};
         SPC_IDX_IRQ_MASK: rd_val = {28'h000_0000, st.irq_mask};
         default: hit = 1'b0;
      endcase
   end

   // Next state: bus capture, register writes, scan stop sequencing and interrupt flags.
   always_comb begin
      next_st = st;
      if (setup) begin
         next_st.prdata = apb_in.pwrite ? 32'h0000_0000 : rd_val;
         next_st.pslverr = ~hit;
      end
      if (wr) begin
         unique case (word)
            SPC_IDX_SENSOR: next_st.sensor_cfg = apb_in.pwdata[7:0];
            SPC_IDX_AUX: next_st.aux_cfg = apb_in.pwdata[7:0];
            SPC_IDX_COMMAND: next_st.command = apb_in.pwdata[7:0];
            SPC_IDX_TRIP_LINES: next_st.trip_lines = apb_in.pwdata[7:0];
            SPC_IDX_IRQ_MASK: next_st.irq_mask = apb_in.pwdata[3:0];
            default: next_st.irq_mask = st.irq_mask;
         endcase
      end
      // Pending stop counts lines; abandoned if software stops or drops the option.
      if (trip && st.trip_lines != 8'h00) begin
         next_st.pending = 1'b1;
         next_st.remaining = st.trip_lines;
      end else if (st.pending && line_done_in && st.remaining != 8'h01) begin
         next_st.remaining = st.remaining - 8'h01;
      end
      if (!st.sensor_cfg[SPC_PS_STOP] || (cmd_wr && !apb_in.pwdata[0])) begin
         next_st.pending = 1'b0;
      end
      // The sensor stop overrides a same-cycle command write.
      if (stop_now) begin
         next_st.command = 8'h00;
         next_st.pending = 1'b0;
      end
      // Sticky interrupt bits; an event in the clearing cycle survives.
      next_st.irq_stat = st.irq_stat & ~((wr && word == SPC_IDX_IRQ_STATUS) ? apb_in.pwdata[3:0] : 4'h0);
      next_st.irq_stat = next_st.irq_stat | {stop_now, cond_rise};
   end

   // Single state register.
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         st.sensor_cfg <= SPC_RESET_CFG;
         st.aux_cfg <= SPC_RESET_CFG;
         st.command <= SPC_RESET_COMMAND;
         st.trip_lines <= SPC_RESET_TRIP_LINES;
         st.remaining <= 8'h00;
         st.pending <= 1'b0;
         st.irq_stat <= SPC_RESET_IRQ;
         st.irq_mask <= SPC_RESET_IRQ;
         st.prdata <= 32'h0000_0000;
         st.pslverr <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // Zero-wait access phase; data and error were captured in the setup cycle.
   assign pready_out = done;
   assign pslverr_out = done & st.pslverr;
   assign prdata_out = st.prdata;
   assign command_out = st.command;
   assign irq_out = |(st.irq_stat & st.irq_mask);

   // Checks on the design's own behaviour.
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (reset_in);

   sequence aux_write_s;
      wr && word == SPC_IDX_AUX;
   endsequence

   sequence cmd_quiet_s;
      !cmd_wr;
   endsequence

   aux1_direction_a: assert property (aux_write_s |=> aux_pin_oe_out[0] == $past(apb_in.pwdata[0]))
      else $error("aux pin 1 enable does not follow its direction bit");

   aux2_direction_a: assert property (aux_write_s |=> aux_pin_oe_out[1] == $past(apb_in.pwdata[4]))
      else $error("aux pin 2 enable does not follow its direction bit");

   aux1_drive_a: assert property (
      aux_write_s ##1 aux_pin_oe_out[0] |-> aux_pin_out[0] == $past(apb_in.pwdata[3]))
      else $error("aux pin 1 output level does not follow its output bit");

   sensor_polarity_a: assert property ((st.sensor_cfg[SPC_PS_POL] == sensor2_in)[*3] |-> cond_true[0])
      else $error("sensor level matching polarity not seen as true");

   aux1_polarity_a: assert property (
      (st.aux_cfg[SPC_AUX_POL] == aux_pin_in[0] && !st.aux_cfg[SPC_AUX_DIR])[*3] |-> cond_true[1])
      else $error("aux pin 1 level matching polarity not seen as true");

   aux2_polarity_a: assert property (
      (st.aux_cfg[5] == aux_pin_in[1] && !st.aux_cfg[4])[*3] |-> cond_true[2])
      else $error("aux pin 2 level matching polarity not seen as true");

   sensor_level_a: assert property (!st.sensor_cfg[SPC_PS_EDGE] |-> status[0] == cond_true[0])
      else $error("sensor level status differs from current truth");

   aux_level_a: assert property (
      !st.aux_cfg[SPC_AUX_EDGE] && !st.aux_cfg[6] |-> status[2:1] == cond_true[2:1])
      else $error("aux level status differs from current truth");

   sensor_edge_a: assert property (
      st.sensor_cfg[SPC_PS_EDGE] && cond_true[0] ##1 st.sensor_cfg[SPC_PS_EDGE] |-> status[0])
      else $error("sensor edge sighting was lost");

   aux1_edge_a: assert property (
      st.aux_cfg[SPC_AUX_EDGE] && cond_true[1] ##1 st.aux_cfg[SPC_AUX_EDGE] && !st.aux_cfg[0] |-> status[1])
      else $error("aux pin 1 edge sighting was lost");

   aux2_edge_a: assert property (
      st.aux_cfg[6] && cond_true[2] ##1 st.aux_cfg[6] && !st.aux_cfg[4] |-> status[2])
      else $error("aux pin 2 edge sighting was lost");

   aux_output_masked_a: assert property (st.aux_cfg[SPC_AUX_DIR] |-> !status[1] && !cond_rise[1])
      else $error("aux pin 1 input reported while driven as output");

   stop_off_a: assert property ((!st.sensor_cfg[SPC_PS_STOP] and cmd_quiet_s) |=> $stable(st.command))
      else $error("command changed with stop option off");

   stop_now_a: assert property (trip && st.trip_lines == 8'h00 |=> st.command == 8'h00 ##1 !st.pending)
      else $error("immediate sensor stop did not clear command");

   stop_deferred_a: assert property (
      ((st.pending && !line_done_in && st.sensor_cfg[SPC_PS_STOP]) and cmd_quiet_s) |=> st.command[0] && st.pending)
      else $error("scan stopped before the post-trip lines were done");

   stop_final_a: assert property (
      st.pending && line_done_in && st.remaining == 8'h01 && st.sensor_cfg[SPC_PS_STOP]
      |=> st.command == 8'h00 && st.irq_stat[SPC_IRQ_STOPPED])
      else $error("last post-trip line did not end the scan");

   // Bus steps: a setup cycle followed by its access cycle.
   sequence read_setup_s;
      setup && !apb_in.pwrite;
   endsequence

   sequence access_s;
      done;
   endsequence

   read_data_a: assert property (
      read_setup_s ##1 access_s |-> prdata_out == $past(rd_val))
      else $error("read data differs from the word addressed at setup");

   bus_error_a: assert property (
      setup ##1 access_s |-> pslverr_out != $past(hit))
      else $error("error response does not match the address decode");

   bus_idle_a: assert property (
      !done |-> !pready_out && !pslverr_out)
      else $error("bus answer outside an access cycle");

   prdata_hold_a: assert property (
      !setup |=> $stable(prdata_out))
      else $error("read data changed outside a setup cycle");

   // Register writes and interrupt flags; a flag event beats a clearing write.
   trip_write_a: assert property (
      wr && word == SPC_IDX_TRIP_LINES |=> st.trip_lines == $past(apb_in.pwdata[7:0]))
      else $error("trip line count write did not land");

   command_write_a: assert property (
      cmd_wr && !stop_now |=> command_out == $past(apb_in.pwdata[7:0]))
      else $error("command write did not land");

   aux2_drive_a: assert property (
      aux_write_s ##1 aux_pin_oe_out[1] |-> aux_pin_out[1] == $past(apb_in.pwdata[7]))
      else $error("aux pin 2 output level does not follow its output bit");

   irq_set_a: assert property (
      cond_rise[0] |=> st.irq_stat[SPC_IRQ_SENSOR])
      else $error("sensor rise did not set its interrupt flag");

   irq_sticky_a: assert property (
      st.irq_stat[SPC_IRQ_STOPPED] && !(wr && word == SPC_IDX_IRQ_STATUS) |=> st.irq_stat[SPC_IRQ_STOPPED])
      else $error("stop interrupt flag dropped without a clearing write");

   // Input capture and scan stop steps.
   sensor_sync_a: assert property (
      !$past(reset_in) && !$past(reset_in, 2) && !$past(reset_in, 3) && !$stable(cond_true[0])
      && $stable(st.sensor_cfg[SPC_PS_POL]) |-> $past(sensor2_in, 2) != $past(sensor2_in, 3))
      else $error("sensor truth changed without a pin change two cycles earlier");

   sensor_hold_a: assert property (
      st.sensor_cfg[SPC_PS_EDGE] && status[0] && !read_clear[0] ##1 st.sensor_cfg[SPC_PS_EDGE] |-> status[0])
      else $error("sensor edge status dropped without a status read");

   sensor_clear_a: assert property (
      st.sensor_cfg[SPC_PS_EDGE] && read_clear[0] && !cond_true[0] ##1 st.sensor_cfg[SPC_PS_EDGE] |-> !status[0])
      else $error("sensor edge status survived the read that returned it");

   aux1_hold_a: assert property (
      st.aux_cfg[SPC_AUX_EDGE] && !st.aux_cfg[SPC_AUX_DIR] && status[1] && !read_clear[1]
      ##1 st.aux_cfg[SPC_AUX_EDGE] && !st.aux_cfg[SPC_AUX_DIR] |-> status[1])
      else $error("aux pin 1 edge status dropped without a status read");

   aux1_clear_a: assert property (
      st.aux_cfg[SPC_AUX_EDGE] && read_clear[1] && !cond_true[1] ##1 st.aux_cfg[SPC_AUX_EDGE] |-> !status[1])
      else $error("aux pin 1 edge status survived the read that returned it");

   aux2_hold_a: assert property (
      st.aux_cfg[SPC_AUX_STRIDE + SPC_AUX_EDGE] && !st.aux_cfg[SPC_AUX_STRIDE + SPC_AUX_DIR] && status[2]
      && !read_clear[2] ##1 st.aux_cfg[SPC_AUX_STRIDE + SPC_AUX_EDGE] && !st.aux_cfg[SPC_AUX_STRIDE + SPC_AUX_DIR]
      |-> status[2])
      else $error("aux pin 2 edge status dropped without a status read");

   rise_once_a: assert property (
      cond_rise[0] |=> !cond_rise[0])
      else $error("sensor transition reported twice");

   trip_arms_a: assert property (
      ((trip && st.trip_lines != 8'h00) and cmd_quiet_s) |=> st.pending && st.remaining == $past(st.trip_lines))
      else $error("deferred stop not armed with the programmed line count");

   count_down_a: assert property (
      st.pending && line_done_in && st.remaining != 8'h01 |=> st.remaining == $past(st.remaining) - 8'h01)
      else $error("post-trip line count did not step down");

   stop_cancel_a: assert property (
      st.pending && !st.sensor_cfg[SPC_PS_STOP] |=> !st.pending)
      else $error("pending stop kept after the stop option was dropped");

endmodule

// [spc_pin_far.sv]
// Far-side model of the paper sensor and the two auxiliary signals, resolving each shared pin.
`timescale 1ns/1ps
module spc_pin_far (
   input wire logic sensor_level_in,
   input wire logic [1:0] aux_level_in,
   input wire logic [1:0] aux_drive_in,
   input wire logic [1:0] aux_drive_oe_in,
   output logic sensor2_out,
   output logic [1:0] aux_wire_out
);
   // The sensor is a plain switch, so its level always reaches the pin.
   assign sensor2_out = sensor_level_in;
   // A driven pin shows the block's level; otherwise the external source drives it.
   // Both sides driving at once would be a board fault, so the block always wins here.
   assign aux_wire_out[0] = aux_drive_oe_in[0] ? aux_drive_in[0] : aux_level_in[0];
   assign aux_wire_out[1] = aux_drive_oe_in[1] ? aux_drive_in[1] : aux_level_in[1];
endmodule

// [test_sensor_and_aux_pin_control.sv]
// Self-checking testbench for the paper sensor and auxiliary pin control block.
`timescale 1ns/1ps
module test_sensor_and_aux_pin_control import spc_pkg::*;;
   localparam logic [11:0] A_SENS = {SPC_IDX_SENSOR, 2'b00};
   localparam logic [11:0] A_AUX = {SPC_IDX_AUX, 2'b00};
   localparam logic [11:0] A_STAT = {SPC_IDX_STATUS, 2'b00};
   localparam logic [11:0] A_CMD = {SPC_IDX_COMMAND, 2'b00};
   localparam logic [11:0] A_TRIP = {SPC_IDX_TRIP_LINES, 2'b00};
   localparam logic [11:0] A_IRQ = {SPC_IDX_IRQ_STATUS, 2'b00};
   localparam logic [11:0] A_MASK = {SPC_IDX_IRQ_MASK, 2'b00};
   localparam int LIMIT = 20000;
   logic clk_in, reset_in, pready_out, pslverr_out, line_done_in, irq_out, sensor_lvl, sensor2;
   logic [31:0] prdata_out, rd, last_err;
   logic [1:0] aux_lvl, aux_wire, aux_pin_out, aux_pin_oe_out;
   logic [7:0] command_out;
   spc_apb_req_t apb;
   int fails, checked, cycles;

   spc_pin_ctrl i_dut (.clk_in(clk_in), .reset_in(reset_in), .apb_in(apb), .pready_out(pready_out),
      .pslverr_out(pslverr_out), .prdata_out(prdata_out), .sensor2_in(sensor2), .aux_pin_in(aux_wire),
      .aux_pin_out(aux_pin_out), .aux_pin_oe_out(aux_pin_oe_out), .line_done_in(line_done_in),
      .command_out(command_out), .irq_out(irq_out));
   spc_pin_far i_far (.sensor_level_in(sensor_lvl), .aux_level_in(aux_lvl), .aux_drive_in(aux_pin_out),
      .aux_drive_oe_in(aux_pin_oe_out), .sensor2_out(sensor2), .aux_wire_out(aux_wire));

   // Free-running system clock at 10 MHz.
   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end

   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // A hang anywhere ends the run through the same closing report.
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         fails++;
         complete_run();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One APB transfer; the request is held until pready is sampled high at a rising edge.
   task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] data);
      @(posedge clk_in);
      apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: data};
      @(posedge clk_in);
      apb.penable <= 1'b1;
      do @(posedge clk_in); while (pready_out !== 1'b1);
      rd = prdata_out;
      last_err = {31'h0, pslverr_out};
      apb.psel <= 1'b0;
      apb.penable <= 1'b0;
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   // Settles inputs past the synchroniser, then reads the status register.
   task automatic read_status(input int n);
      idle(n);
      xfer(1'b0, A_STAT, 32'h0);
   endtask

   task automatic line_pulse();
      @(posedge clk_in);
      line_done_in <= 1'b1;
      @(posedge clk_in);
      line_done_in <= 1'b0;
   endtask

   initial begin
      apb = '0;
      reset_in = 1'b1;
      line_done_in = 1'b0;
      sensor_lvl = 1'b0;
      aux_lvl = 2'h0;
      fails = 0;
      checked = 0;
      cycles = 0;
      repeat (8) @(posedge clk_in);
      reset_in <= 1'b0;
      // Reset values and an unmapped word.
      xfer(1'b0, A_AUX, 32'h0);
      chk("aux_cfg reset", 32'h0, rd);
      xfer(1'b0, A_SENS, 32'h0);
      chk("sensor_cfg reset", 32'h0, rd);
      xfer(1'b0, 12'h1FC, 32'h0);
      chk("unmapped pslverr", 32'h1, last_err);
      // Pins as outputs follow the output bits; their status stays clear.
      xfer(1'b1, A_AUX, 32'h0000_0099);
      idle(1);
      chk("oe both", 32'h3, {30'h0, aux_pin_oe_out});
      chk("wire high", 32'h3, {30'h0, aux_wire});
      xfer(1'b1, A_AUX, 32'h0000_0011);
      read_status(4);
      chk("wire low", 32'h0, {30'h0, aux_wire});
      chk("output pin status", 32'h0, rd & 32'h0000_0006);
      // Level mode over both polarities and both pin levels.
      for (int p = 0; p < 2; p++) begin
         xfer(1'b1, A_AUX, p[0] ? 32'h0000_0022 : 32'h0000_0000);
         xfer(1'b1, A_SENS, p[0] ? 32'h0000_0008 : 32'h0000_0000);
         for (int l = 0; l < 2; l++) begin
            sensor_lvl <= l[0];
            aux_lvl <= {2{l[0]}};
            read_status(4);
            chk("level", {29'h0, {3{l[0] == p[0]}}}, rd & 32'h1F);
         end
      end
      // Edge mode latches a short true pulse until one status read.
      sensor_lvl <= 1'b0;
      aux_lvl <= 2'h0;
      xfer(1'b1, A_AUX, 32'h0000_0066);
      xfer(1'b1, A_SENS, 32'h0000_0018);
      xfer(1'b1, A_IRQ, 32'h0000_000F);
      idle(4);
      sensor_lvl <= 1'b1;
      aux_lvl <= 2'h3;
      idle(3);
      sensor_lvl <= 1'b0;
      aux_lvl <= 2'h0;
      read_status(4);
      chk("edge latched", 32'h7, rd & 32'h0000_0007);
      read_status(1);
      chk("edge cleared by read", 32'h0, rd & 32'h0000_0007);
      // Interrupt: raised, masked, unmasked, then cleared by writing ones.
      chk("irq masked", 32'h0, {31'h0, irq_out});
      xfer(1'b1, A_MASK, 32'h0000_000F);
      xfer(1'b0, A_MASK, 32'h0);
      chk("mask readback", 32'hF, rd);
      idle(1);
      chk("irq raised", 32'h1, {31'h0, irq_out});
      xfer(1'b1, A_IRQ, 32'h0000_0007);
      idle(1);
      chk("irq cleared", 32'h0, {31'h0, irq_out});
      // Stop option off: a sensor trip leaves the scan running.
      xfer(1'b1, A_SENS, 32'h0000_0008);
      xfer(1'b1, A_CMD, 32'h0000_0001);
      sensor_lvl <= 1'b1;
      idle(6);
      chk("no stop", 32'h1, {24'h0, command_out});
      // Stop option on, with no deferral and with a two-line deferral.
      xfer(1'b1, A_SENS, 32'h0000_0028);
      for (int n = 0; n < 3; n += 2) begin
         xfer(1'b1, A_TRIP, n);
         xfer(1'b1, A_CMD, 32'h0000_0001);
         sensor_lvl <= 1'b0;
         idle(4);
         sensor_lvl <= 1'b1;
         idle(4);
         read_status(0);
         chk("scan and pending", n != 0 ? 32'h18 : 32'h0, rd & 32'h18);
         for (int i = 0; i < n; i++) begin
            chk("scan held", 32'h1, {24'h0, command_out});
            line_pulse();
         end
         idle(2);
         chk("scan stopped", 32'h0, {24'h0, command_out});
         xfer(1'b0, A_IRQ, 32'h0);
         chk("stop irq", 32'h8, rd & 32'h0000_0008);
         xfer(1'b1, A_IRQ, 32'h0000_000F);
      end
      complete_run();
   end
endmodule
